// File: src/thermal_slave_consts.vh
/*
 * Constants of the two-wire slave port of the temperature monitor:
 * bus addresses, register pointer values, configuration layout, strap codes.
 * Assumes inclusion by the slave port module only; definitions only.
 */
`ifndef THERMAL_SLAVE_CONSTS_VH
`define THERMAL_SLAVE_CONSTS_VH

// Alert response address, never a device address
`define ALERT_RESP_ADDR 7'h0C
// Base addresses picked by the first strap
`define BASE_ADDR_LOW 7'h18
`define BASE_ADDR_OPEN 7'h29
`define BASE_ADDR_HIGH 7'h4C

// Three-level strap codes as presented at the strap inputs
`define STRAP_LOW 2'h0
`define STRAP_OPEN 2'h1

// Register pointer values
`define PTR_CFG_RD 8'h03
`define PTR_CFG_WR 8'h09
`define PTR_ONESHOT_WR 8'h0F
`define PTR_RESET 8'h00

// Configuration register
`define CFG_RESET 8'h00
`define CFG_MASK_BIT 7
`define CFG_STANDBY_PIN_N_BIT 6

// Cycles after reset release before straps are captured
`define STRAP_SETTLE 2'h3

// Bits per byte before the acknowledge slot
`define BITS_PER_BYTE 4'h8
// Write bytes accepted after the address
`define MAX_WR_BYTES 2'h2

`endif

// File: src/smbus_thermal_monitor_slave_port.v
/*
 * Two-wire slave port of a digital temperature monitor: start/stop
 * detection, address match from straps, pointer and register writes,
 * one-shot trigger, open-drain alert with alert-response handling.
 * Assumes the conversion engine, comparators and data registers sit
 * outside on core_clk; bus pins and straps arrive asynchronously.
 */
// Summary of operation
// - One-shot write in standby starts one conversion.
// - One-shot data byte is ignored, never stored.
// - Each strap decodes low, open or high.
// - First strap picks base, second adds 0-2.
// - Straps captured once after each reset release.
// - Start then seven address bits, direction bit.
// - Acknowledge own address or alert response, otherwise stay idle.
// - Direction 0 writes, direction 1 reads.
// - Nine clocks per byte, slave acks writes.
// - Data changes only with clock low; stop detection.
// - Direction fixed until next start.
// - Writes carry one or two bytes; reads one.
// - First write byte loads register pointer.
// - Second write byte goes to pointed register.
// - Read returns register at current pointer.
// - Separate read and write pointer values.
// - Alert asserts on limit fault or open sensor.
// - Alert pin is open-drain, drives low only.
// - Alert-response read returns own address.
// - Lose arbitration, back off the bus.
// - Release alert after response if fault cleared.
// - Mask bit set disables alert, reset clear.
// - Standby pin low blocks one-shot too.
// - Only alert-response read clears the alert latch.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_slave_consts.vh"

module smbus_thermal_monitor_slave_port (
	input wire core_clk,
	input wire rst,
	input wire scl_pin,
	input wire serial_data_pin_i,
	output reg serial_data_pin_o,
	output reg serial_data_pin_oe,
	input wire [1:0] addr_strap_first,
	input wire [1:0] addr_strap_second,
	input wire standby_pin_n,
	input wire limit_fault,
	input wire sensor_open,
	input wire status_flags_clear,
	input wire [7:0] reg_rd_data,
	output reg [7:0] reg_rd_addr,
	output reg reg_wr_strobe,
	output reg [7:0] reg_wr_addr,
	output reg [7:0] reg_wr_data,
	output reg conversion_trigger,
	output reg conversion_enable,
	output reg alarm_mask_bit,
	output reg [6:0] device_addr,
	output reg alert_pin_o,
	output reg alert_pin_oe
);

	localparam ST_IDLE = 6'b00_0001;
	localparam ST_ADDR = 6'b00_0010;
	localparam ST_ACK = 6'b00_0100;
	localparam ST_RX = 6'b00_1000;
	localparam ST_TX = 6'b01_0000;
	localparam ST_MACK = 6'b10_0000;

	// Two-stage synchronisers; third stage only for edge detection
	reg scl_s1_q, scl_s2_q, scl_s3_q;
	reg sda_s1_q, sda_s2_q, sda_s3_q;
	reg standby_pin_n_s1_q, standby_pin_n_s2_q;
	reg [1:0] strap0_s1_q, strap0_s2_q;
	reg [1:0] strap1_s1_q, strap1_s2_q;

	reg [1:0] settle_q;
	reg addr_valid_q;
	reg [5:0] state_q;
	reg [3:0] bit_cnt_q;
	reg [1:0] byte_cnt_q;
	reg [7:0] shift_q;
	reg [7:0] tx_q;
	reg rw_q;
	reg ara_q;
	reg [7:0] cfg_q;
	reg alert_latch_q;

	wire scl_rise = scl_s2_q & ~scl_s3_q;
	wire scl_fall = ~scl_s2_q & scl_s3_q;
	wire scl_high = scl_s2_q & scl_s3_q;
	wire start_det = scl_high & sda_s3_q & ~sda_s2_q;
	wire stop_det = scl_high & ~sda_s3_q & sda_s2_q;
	wire fault_now = limit_fault | sensor_open;

	// Strap decode: third level presented as a separate code
	reg [6:0] base_addr;
	reg [6:0] addr_step;
	always @* begin
		if (strap0_s2_q == `STRAP_LOW) begin
			base_addr = `BASE_ADDR_LOW;
		end else if (strap0_s2_q == `STRAP_OPEN) begin
			base_addr = `BASE_ADDR_OPEN;
		end else begin
			base_addr = `BASE_ADDR_HIGH;
		end
		if (strap1_s2_q == `STRAP_LOW) begin
			addr_step = 7'h00;
		end else if (strap1_s2_q == `STRAP_OPEN) begin
			addr_step = 7'h01;
		end else begin
			addr_step = 7'h02;
		end
	end

	// Byte returned on a read
	reg [7:0] tx_byte;
	always @* begin
		if (ara_q) begin
			tx_byte = {device_addr, 1'b0};
		end else if (reg_rd_addr == `PTR_CFG_RD) begin
			tx_byte = cfg_q;
		end else begin
			tx_byte = reg_rd_data;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			standby_pin_n_s1_q <= 1'b1;
			standby_pin_n_s2_q <= 1'b1;
			strap0_s1_q <= 2'h0;
			strap0_s2_q <= 2'h0;
			strap1_s1_q <= 2'h0;
			strap1_s2_q <= 2'h0;
		end else begin
			scl_s1_q <= scl_pin;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= serial_data_pin_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			standby_pin_n_s1_q <= standby_pin_n;
			standby_pin_n_s2_q <= standby_pin_n_s1_q;
			strap0_s1_q <= addr_strap_first;
			strap0_s2_q <= strap0_s1_q;
			strap1_s1_q <= addr_strap_second;
			strap1_s2_q <= strap1_s1_q;
		end
	end

	// Address is latched once; later strap moves are never looked at
	always @(posedge core_clk) begin
		if (rst) begin
			settle_q <= 2'h0;
			addr_valid_q <= 1'b0;
			device_addr <= 7'h00;
		end else if (!addr_valid_q) begin
			if (settle_q == `STRAP_SETTLE) begin
				addr_valid_q <= 1'b1;
				device_addr <= base_addr + addr_step;
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			byte_cnt_q <= 2'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			ara_q <= 1'b0;
			cfg_q <= `CFG_RESET;
			alert_latch_q <= 1'b0;
			reg_rd_addr <= `PTR_RESET;
			reg_wr_strobe <= 1'b0;
			reg_wr_addr <= 8'h00;
			reg_wr_data <= 8'h00;
			conversion_trigger <= 1'b0;
			conversion_enable <= 1'b0;
			alarm_mask_bit <= 1'b0;
			serial_data_pin_o <= 1'b0;
			serial_data_pin_oe <= 1'b0;
			alert_pin_o <= 1'b0;
			alert_pin_oe <= 1'b0;
		end else begin
			reg_wr_strobe <= 1'b0;
			conversion_trigger <= 1'b0;
			case (state_q)
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s2_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
						if (state_q == ST_ADDR) begin
							if (addr_valid_q && shift_q[7:1] == device_addr) begin
								serial_data_pin_oe <= 1'b1;
								rw_q <= shift_q[0];
								ara_q <= 1'b0;
								state_q <= ST_ACK;
							end else if (addr_valid_q && shift_q[7:1] == `ALERT_RESP_ADDR && shift_q[0] && alert_pin_oe) begin
								serial_data_pin_oe <= 1'b1;
								rw_q <= 1'b1;
								ara_q <= 1'b1;
								state_q <= ST_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end else if (byte_cnt_q == 2'h0) begin
							reg_rd_addr <= shift_q;
							serial_data_pin_oe <= 1'b1;
							byte_cnt_q <= 2'h1;
							state_q <= ST_ACK;
						end else if (byte_cnt_q == 2'h1) begin
							serial_data_pin_oe <= 1'b1;
							byte_cnt_q <= `MAX_WR_BYTES;
							state_q <= ST_ACK;
							if (reg_rd_addr == `PTR_ONESHOT_WR) begin
								// Only the access counts; the byte is dropped
								conversion_trigger <= standby_pin_n_s2_q & cfg_q[`CFG_STANDBY_PIN_N_BIT];
							end else if (reg_rd_addr == `PTR_CFG_WR) begin
								cfg_q <= {shift_q[7:6], 6'h00};
							end else begin
								reg_wr_strobe <= 1'b1;
								reg_wr_addr <= reg_rd_addr;
								reg_wr_data <= shift_q;
							end
						end else begin
							// Third byte is not acknowledged
							state_q <= ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						if (rw_q) begin
							serial_data_pin_oe <= ~tx_byte[7];
							tx_q <= {tx_byte[6:0], 1'b0};
							state_q <= ST_TX;
						end else begin
							serial_data_pin_oe <= 1'b0;
							state_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						// Released a one but the line is low: another talker won
						if (!serial_data_pin_oe && !sda_s2_q) begin
							state_q <= ST_IDLE;
						end
					end else if (scl_fall) begin
						if (bit_cnt_q == `BITS_PER_BYTE) begin
							serial_data_pin_oe <= 1'b0;
							state_q <= ST_MACK;
						end else begin
							serial_data_pin_oe <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						// One byte per read; wait for stop or restart
						state_q <= ST_IDLE;
						if (ara_q && !fault_now && status_flags_clear) begin
							alert_latch_q <= 1'b0;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			if (start_det) begin
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				byte_cnt_q <= 2'h0;
				ara_q <= 1'b0;
				serial_data_pin_oe <= 1'b0;
			end else if (stop_det) begin
				state_q <= ST_IDLE;
				serial_data_pin_oe <= 1'b0;
			end
			// New fault wins over a same-cycle clear
			if (fault_now) begin
				alert_latch_q <= 1'b1;
			end
			alert_pin_oe <= alert_latch_q & ~cfg_q[`CFG_MASK_BIT];
			alarm_mask_bit <= cfg_q[`CFG_MASK_BIT];
			conversion_enable <= standby_pin_n_s2_q & ~cfg_q[`CFG_STANDBY_PIN_N_BIT];
		end
	end

endmodule // smbus_thermal_monitor_slave_port

`default_nettype wire

// File: testbench/bus_master_model.sv
/* Two-wire bus master model: start, stop, byte writes and reads.
 * Assumes a pull-up on the data line; sda is the resolved wire level. */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	localparam realtime Q = 31.25;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic put(input logic b);
		sda_low = !b;
		#Q scl = 1'b1;
		#(2 * Q) scl = 1'b0;
		#Q;
	endtask
	task automatic get(output logic b);
		sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q b = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic send(input logic [7:0] d, inout logic nak);
		logic a;
		for (int i = 7; i >= 0; i--)
			put(d[i]);
		get(a);
		nak = nak | a;
	endtask
	task automatic start();
		sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#(4 * Q);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d, input logic two, output logic nak);
		nak = 1'b0;
		start();
		send({a, 1'b0}, nak);
		send(p, nak);
		if (two)
			send(d, nak);
		stop();
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic nak);
		nak = 1'b0;
		start();
		send({a, 1'b1}, nak);
		for (int i = 7; i >= 0; i--)
			get(d[i]);
		put(1'b1); // One byte only, then not-acknowledge
		stop();
	endtask
endmodule // bus_master_model
`default_nettype wire

// File: testbench/thermal_port_chk.sv
/* Checker of the slave port pins and register side.
 * Assumes binding to the slave port; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module thermal_port_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic serial_data_pin_o,
	input wire logic serial_data_pin_oe,
	input wire logic alert_pin_o,
	input wire logic alert_pin_oe,
	input wire logic alarm_mask_bit,
	input wire logic limit_fault,
	input wire logic sensor_open,
	input wire logic standby_pin_n,
	input wire logic conversion_trigger,
	input wire logic conversion_enable,
	input wire logic reg_wr_strobe,
	input wire logic [7:0] reg_wr_addr,
	input wire logic [7:0] reg_rd_addr,
	input wire logic [6:0] device_addr
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence fault_held;
		((limit_fault || sensor_open) && !alarm_mask_bit)[*3];
	endsequence
	sequence mask_held;
		alarm_mask_bit[*2];
	endsequence
	chk_open_drain: assert property (!serial_data_pin_o && !alert_pin_o) else $error("pin driven high");
	chk_alert_on_fault: assert property (fault_held |=> ##1 alert_pin_oe) else $error("alert missing");
	chk_mask_blocks_alert: assert property (mask_held |-> !alert_pin_oe) else $error("masked alert");
	chk_trig_single: assert property (conversion_trigger |=> !conversion_trigger) else $error("long trigger");
	chk_trig_standby: assert property (conversion_trigger |-> !conversion_enable && standby_pin_n)
		else $error("trigger outside standby");
	chk_wr_at_ptr: assert property (reg_wr_strobe |-> reg_wr_addr == reg_rd_addr) else $error("write off ptr");
	chk_oneshot_nostore: assert property (reg_wr_strobe |-> reg_wr_addr != 8'h0F) else $error("data stored");
	chk_addr_frozen: assert property (device_addr != 7'h00 |=> $stable(device_addr)) else $error("addr moved");
	chk_no_early_ack: assert property (device_addr == 7'h00 |-> !serial_data_pin_oe) else $error("early ack");
endmodule // thermal_port_chk
bind smbus_thermal_monitor_slave_port thermal_port_chk thermal_port_chk_i (.core_clk, .rst, .serial_data_pin_o,
	.serial_data_pin_oe, .alert_pin_o, .alert_pin_oe, .alarm_mask_bit, .limit_fault, .sensor_open, .standby_pin_n,
	.conversion_trigger, .conversion_enable, .reg_wr_strobe, .reg_wr_addr, .reg_rd_addr, .device_addr);
`default_nettype wire

// File: testbench/tb_top.sv
/* Bench of the slave port: straps, pointer and data writes, reads,
 * one-shot, alert response. Assumes the master model and the checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] s0 = 2'h0;
	logic [1:0] s1 = 2'h0;
	logic standby_pin_n_n = 1'b1;
	logic fault = 1'b0;
	logic lim = 1'b0;
	logic clr = 1'b1;
	logic scl, m_low, oe, a_oe, strb, trig, cen, mask, nak;
	logic [7:0] rp, wa, wd, rd;
	logic [6:0] dev;
	logic [6:0] base [3] = '{7'h18, 7'h29, 7'h4C};
	wire logic sda = !(m_low || oe);
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_trig = 0;
	int n_strb = 0;
	always #5 core_clk = !core_clk;
	bus_master_model bus_master_model_i (.scl(scl), .sda_low(m_low), .sda(sda));
	smbus_thermal_monitor_slave_port smbus_thermal_monitor_slave_port_i (.core_clk(core_clk), .rst(rst),
		.scl_pin(scl), .serial_data_pin_i(sda), .serial_data_pin_o(), .serial_data_pin_oe(oe),
		.addr_strap_first(s0), .addr_strap_second(s1), .standby_pin_n(standby_pin_n_n), .limit_fault(lim),
		.sensor_open(fault), .status_flags_clear(clr), .reg_rd_data(~rp), .reg_rd_addr(rp), .reg_wr_strobe(strb),
		.reg_wr_addr(wa), .reg_wr_data(wd), .conversion_trigger(trig), .conversion_enable(cen),
		.alarm_mask_bit(mask), .device_addr(dev), .alert_pin_o(), .alert_pin_oe(a_oe));
	task automatic test_done();
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Ceiling far above the roughly 4600 cycles the sequence needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		n_trig <= n_trig + int'(trig);
		n_strb <= n_strb + int'(strb);
		if (cyc == 30000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic w(input logic [6:0] a, input logic [7:0] p, d, input logic two, exp_nak);
		bus_master_model_i.wr(a, p, d, two, nak);
		chk("write ack", {7'h0, exp_nak}, {7'h0, nak});
	endtask
	task automatic r(input logic [6:0] a, input logic exp_nak, input logic [7:0] exp);
		bus_master_model_i.rd(a, rd, nak);
		chk("read ack", {7'h0, exp_nak}, {7'h0, nak});
		chk("read data", exp, rd);
	endtask
	initial begin
		for (int i = 0; i < 9; i++) begin
			@(negedge core_clk);
			s0 = 2'(i / 3);
			s1 = 2'(i % 3);
			rst = 1'b1;
			repeat (4) @(negedge core_clk);
			rst = 1'b0;
			repeat (8) @(negedge core_clk);
			chk("address", {1'b0, base[i / 3] + 7'(i % 3)}, {1'b0, dev});
		end
		chk("mask at reset", 8'h00, {7'h0, mask});
		chk("run at reset", 8'h01, {7'h0, cen});
		s0 = 2'h0;
		s1 = 2'h1;
		repeat (8) @(negedge core_clk);
		chk("address held", 8'h4E, {1'b0, dev});
		w(7'h4D, 8'h05, 8'hA5, 1'b1, 1'b1);
		w(7'h4E, 8'h05, 8'hA5, 1'b1, 1'b0);
		chk("write addr", 8'h05, wa);
		chk("write data", 8'hA5, wd);
		r(7'h4E, 1'b0, 8'hFA);
		r(7'h4E, 1'b0, 8'hFA);
		w(7'h4E, 8'h09, 8'hC0, 1'b1, 1'b0);
		chk("mask", 8'h01, {7'h0, mask});
		chk("standby bit", 8'h00, {7'h0, cen});
		// Fault while masked: latch sets but the pin stays released
		@(negedge core_clk);
		lim = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("alert masked", 8'h00, {7'h0, a_oe});
		lim = 1'b0;
		r(7'h4E, 1'b0, 8'hF6);
		w(7'h4E, 8'h03, 8'h00, 1'b0, 1'b0);
		r(7'h4E, 1'b0, 8'hC0);
		w(7'h4E, 8'h0F, 8'h5A, 1'b1, 1'b0);
		chk("triggers", 8'h01, n_trig[7:0]);
		chk("stores", 8'h01, n_strb[7:0]);
		@(negedge core_clk);
		standby_pin_n_n = 1'b0;
		w(7'h4E, 8'h0F, 8'h5A, 1'b1, 1'b0);
		chk("triggers blocked", 8'h01, n_trig[7:0]);
		@(negedge core_clk);
		standby_pin_n_n = 1'b1;
		w(7'h4E, 8'h09, 8'h40, 1'b1, 1'b0);
		@(negedge core_clk);
		fault = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("alert on", 8'h01, {7'h0, a_oe});
		r(7'h0C, 1'b0, 8'h9C);
		chk("alert kept", 8'h01, {7'h0, a_oe});
		@(negedge core_clk);
		fault = 1'b0;
		clr = 1'b0;
		r(7'h0C, 1'b0, 8'h9C);
		chk("latch kept", 8'h01, {7'h0, a_oe});
		@(negedge core_clk);
		clr = 1'b1;
		r(7'h0C, 1'b0, 8'h9C);
		repeat (4) @(negedge core_clk);
		chk("alert off", 8'h00, {7'h0, a_oe});
		r(7'h0C, 1'b1, 8'hFF);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
